// ---- fetse_pkg.sv ----
// shared constants, types and code tables of the 100 Mb/s transmit symbol encoder
package fetse_pkg;

   // second control register and its error forwarding disable bit
   localparam logic [15:0] CTRL2_OFFSET = 16'h000A;
   localparam int CTRL2_W = 16;
   localparam int CTRL2_TXERR_FWD_DIS_BIT = 1;

   // control code groups
   localparam logic [4:0] CG_IDLE = 5'h1F;
   localparam logic [4:0] CG_SSD_J = 5'h18;
   localparam logic [4:0] CG_SSD_K = 5'h11;
   localparam logic [4:0] CG_ESD_T = 5'h0D;
   localparam logic [4:0] CG_ESD_R = 5'h07;
   localparam logic [4:0] CG_TX_ERR = 5'h04;
   localparam logic [3:0] NIB_PREAMBLE = 4'h5;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam int GROUP_BITS = 5;
   localparam logic [2:0] GROUP_LAST_BIT = 3'h4;

   // data nibble to code group, indexed by nibble value
   localparam logic [4:0] CG_TABLE [16] = '{
      5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
   };

   // scrambler: 11-bit lfsr, feedback from stages 11 and 9
   localparam int LFSR_W = 11;
   localparam int LFSR_TAP_A = 10;
   localparam int LFSR_TAP_B = 8;
   localparam logic [5:0] SEED_FILL = 6'h2A;

   // line timing: core clock period against one code bit on the line
   localparam int CLK_PERIOD_NS = 5;
   localparam int LINE_BIT_NS = 8;
   localparam int ACC_W = 4;
   localparam logic [ACC_W:0] ACC_STEP = (ACC_W + 1)'(CLK_PERIOD_NS);
   localparam logic [ACC_W:0] ACC_WRAP = (ACC_W + 1)'(LINE_BIT_NS);

   localparam int FIFO_DEPTH = 8;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_SSD_K = 5'h02,
      TX_DATA = 5'h04,
      TX_ESD_T = 5'h08,
      TX_ESD_R = 5'h10
   } fetse_tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_GOT_J = 4'h2,
      RX_DATA = 4'h4,
      RX_GOT_T = 4'h8
   } fetse_rx_state_t;

   typedef enum logic [1:0] {
      MLT3_ZERO = 2'h0,
      MLT3_POS = 2'h1,
      MLT3_NEG = 2'h2
   } fetse_mlt3_t;

   // one transmit clock's worth of mii transmit signals
   typedef struct packed {
      logic en;
      logic er;
      logic [3:0] data;
   } fetse_nib_t;

   // decoded receive nibble with its qualifiers
   typedef struct packed {
      logic stb;
      logic dv;
      logic er;
      logic crs;
      logic [3:0] data;
   } fetse_rx_t;

endpackage : fetse_pkg

// ---- fetse_async_fifo.sv ----
// dual-clock fifo with gray-coded pointers, flip-flop storage
`timescale 1ns/100ps
module fetse_async_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 8
) (
   input wire logic wr_clk_in,
   input wire logic wr_rstn_in,
   input wire logic wr_valid_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   output logic wr_ready_out,
   input wire logic rd_clk_in,
   input wire logic rd_rstn_in,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("fifo depth must be a power of two of at least four");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
   logic [AW:0] wg_meta_q, wg_sync_q, rg_meta_q, rg_sync_q;
   logic [AW:0] wbin_d, rbin_d;
   logic push, pop;

   assign wr_ready_out = (wgray_q != {~rg_sync_q[AW:AW-1], rg_sync_q[AW-2:0]});
   assign rd_valid_out = (rgray_q != wg_sync_q);
   assign push = wr_valid_in & wr_ready_out;
   assign pop = rd_valid_out & rd_ready_in;
   assign wbin_d = wbin_q + {{AW{1'b0}}, push};
   assign rbin_d = rbin_q + {{AW{1'b0}}, pop};
   assign rd_data_out = mem_q[rbin_q[AW-1:0]];

   // storage written on the filling side only
   always_ff @(posedge wr_clk_in) begin
      if (push) begin
         mem_q[wbin_q[AW-1:0]] <= wr_data_in;
      end
   end

   // write pointer and read pointer brought over
   always_ff @(posedge wr_clk_in) begin
      if (!wr_rstn_in) begin
         wbin_q <= '0;
         wgray_q <= '0;
         rg_meta_q <= '0;
         rg_sync_q <= '0;
      end else begin
         wbin_q <= wbin_d;
         wgray_q <= wbin_d ^ (wbin_d >> 1);
         rg_meta_q <= rgray_q;
         rg_sync_q <= rg_meta_q;
      end
   end

   // read pointer and write pointer brought over
   always_ff @(posedge rd_clk_in) begin
      if (!rd_rstn_in) begin
         rbin_q <= '0;
         rgray_q <= '0;
         wg_meta_q <= '0;
         wg_sync_q <= '0;
      end else begin
         rbin_q <= rbin_d;
         rgray_q <= rbin_d ^ (rbin_d >> 1);
         wg_meta_q <= wgray_q;
         wg_sync_q <= wg_meta_q;
      end
   end

endmodule : fetse_async_fifo

// ---- fetse_symbol_encoder.sv ----
// 100 Mb/s transmit symbol path: mii capture, 4b/5b, scrambler, nrzi, mlt-3, 5b/4b decode
`timescale 1ns/100ps
// Overview of operation
// RULE1: mac offers nibbles on mii; idle groups go out whenever no frame is offered
// RULE2: tx enable falling after odd nibble count is stretched one cycle as error
// RULE3: with forwarding on, odd frames get one error nibble just before the end
// RULE4: bit 1 of the second control register turns error forwarding off
// RULE5: with forwarding off, frames pass with their nibble count untouched
// RULE6: each data nibble maps to its fixed 5-bit code group
// RULE7: first two preamble nibbles are replaced by start groups j then k
// RULE8: remaining preamble and data nibbles become their code groups
// RULE9: end of tx enable appends end groups t then r
// RULE10: after the end pair, idle groups repeat until the next frame
// RULE11: receive j after idle and k after j decode to 0101, else error
// RULE12: carrier drops only on t followed by r; lone t or r flags error; the code also drops carrier when j is not followed by k
// RULE13: invalid code groups during valid data flag a receive error
// RULE14: idle or delimiter groups inside data are invalid and flag error
// RULE15: scrambler seed is built from the phy address
// RULE16: scrambled bits are nrzi coded, then turned into mlt-3 levels
// RULE17: a one bit steps the mlt-3 level, a zero holds it
// RULE18: scrambler is an 11-bit lfsr xored onto each serial code bit
module fetse_symbol_encoder #(
   parameter int FIFO_DEPTH = fetse_pkg::FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic tx_clk_in,
   input wire logic mii_txen_in,
   input wire logic mii_txer_in,
   input wire logic [3:0] mii_txd_in,
   input wire logic [fetse_pkg::CTRL2_W-1:0] second_control_register_in,
   input wire logic [4:0] phy_addr_in,
   input wire logic [4:0] rx_group_in,
   input wire logic rx_group_valid_in,
   output logic tx_fifo_ready_out,
   output logic [4:0] code_group_out,
   output logic line_bit_valid_out,
   output logic scr_bit_out,
   output logic nrzi_out,
   output fetse_pkg::fetse_mlt3_t mlt3_out,
   output fetse_pkg::fetse_rx_t rx_nibble_out
);
   import fetse_pkg::*;

   if (ACC_STEP > ACC_WRAP || ACC_WRAP >= (1 << ACC_W)) begin : g_rate_chk
      $error("core clock too slow for the line bit rate");
   end

   // reset brought into the link domain
   logic lrst_meta_q, lrstn_q;

   always_ff @(posedge tx_clk_in) begin
      lrst_meta_q <= rstn_in;
      lrstn_q <= lrst_meta_q;
   end

   // forwarding disable level brought into the link domain
   logic fwd_dis_meta_q, fwd_dis_q;

   always_ff @(posedge tx_clk_in) begin
      if (!lrstn_q) begin
         fwd_dis_meta_q <= 1'b0;
         fwd_dis_q <= 1'b0;
      end else begin
         fwd_dis_meta_q <= second_control_register_in[CTRL2_TXERR_FWD_DIS_BIT]; // RULE4
         fwd_dis_q <= fwd_dis_meta_q;
      end
   end

   // mii capture; the mac drives these from the transmit clock
   fetse_nib_t mii_q;
   logic en_prev_q, odd_q, en_int_q;
   logic ext_now, en_int, push;
   fetse_nib_t wr_rec;

   always_ff @(posedge tx_clk_in) begin
      if (!lrstn_q) begin
         mii_q <= '0;
      end else begin
         mii_q <= '{en: mii_txen_in, er: mii_txer_in, data: mii_txd_in}; // RULE1
      end
   end

   // odd nibble tracking and the one-cycle stretch
   assign ext_now = !mii_q.en && en_prev_q && odd_q && !fwd_dis_q; // RULE2 RULE3 RULE5
   assign en_int = mii_q.en | ext_now;
   assign push = en_int | en_int_q;

   always_comb begin
      wr_rec = mii_q;
      if (ext_now) begin
         wr_rec = '{en: 1'b1, er: 1'b1, data: NIB_ZERO}; // RULE2
      end else if (!en_int) begin
         wr_rec = '{en: 1'b0, er: 1'b0, data: NIB_ZERO};
      end
   end

   always_ff @(posedge tx_clk_in) begin
      if (!lrstn_q) begin
         en_prev_q <= 1'b0;
         odd_q <= 1'b0;
         en_int_q <= 1'b0;
      end else begin
         en_prev_q <= mii_q.en;
         en_int_q <= en_int;
         if (mii_q.en) begin
            odd_q <= ~odd_q; // RULE3
         end else begin
            odd_q <= 1'b0;
         end
      end
   end

   // link to core crossing and buffering
   fetse_nib_t rd_rec;
   logic rd_valid, pop;

   fetse_async_fifo #(
      .WIDTH($bits(fetse_nib_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .wr_clk_in(tx_clk_in),
      .wr_rstn_in(lrstn_q),
      .wr_valid_in(push),
      .wr_data_in(wr_rec),
      .wr_ready_out(tx_fifo_ready_out),
      .rd_clk_in(clk_in),
      .rd_rstn_in(rstn_in),
      .rd_valid_out(rd_valid),
      .rd_ready_in(pop),
      .rd_data_out(rd_rec)
   );

   // line bit strobe from a phase accumulator
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W:0] acc_sum;
   logic bit_stb;

   assign acc_sum = {1'b0, acc_q} + ACC_STEP;
   assign bit_stb = (acc_sum >= ACC_WRAP);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         acc_q <= '0;
      end else if (bit_stb) begin
         acc_q <= ACC_W'(acc_sum - ACC_WRAP);
      end else begin
         acc_q <= acc_sum[ACC_W-1:0];
      end
   end

   // code group selection
   fetse_tx_state_t tx_st_q, tx_st_d;
   logic [2:0] bit_cnt_q;
   logic [4:0] shreg_q;
   logic need_grp, stall, advance, cur_bit;
   logic [4:0] grp;

   assign need_grp = bit_stb && (bit_cnt_q == 3'h0);
   assign stall = need_grp && !rd_valid && (tx_st_q == TX_SSD_K || tx_st_q == TX_DATA);
   assign advance = bit_stb && !stall;
   assign pop = need_grp && rd_valid &&
                (tx_st_q == TX_IDLE || tx_st_q == TX_SSD_K || tx_st_q == TX_DATA);

   always_comb begin
      tx_st_d = tx_st_q;
      grp = CG_IDLE;
      case (tx_st_q)
         TX_IDLE: begin
            grp = CG_IDLE; // RULE10 RULE1
            if (rd_valid && rd_rec.en) begin
               grp = CG_SSD_J; // RULE7
               tx_st_d = TX_SSD_K;
            end
         end
         TX_SSD_K: begin
            grp = CG_SSD_K; // RULE7
            tx_st_d = rd_rec.en ? TX_DATA : TX_ESD_T;
         end
         TX_DATA: begin
            if (!rd_rec.en) begin
               grp = CG_ESD_T; // RULE9
               tx_st_d = TX_ESD_R;
            end else if (rd_rec.er) begin
               grp = CG_TX_ERR;
            end else begin
               grp = CG_TABLE[rd_rec.data]; // RULE6 RULE8
            end
         end
         TX_ESD_T: begin
            grp = CG_ESD_T; // RULE9
            tx_st_d = TX_ESD_R;
         end
         TX_ESD_R: begin
            grp = CG_ESD_R; // RULE9
            tx_st_d = TX_IDLE;
         end
         default: begin
            grp = CG_IDLE;
            tx_st_d = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         tx_st_q <= TX_IDLE;
      end else if (need_grp && !stall) begin
         tx_st_q <= tx_st_d;
      end
   end

   // serializer, most significant code bit first
   assign cur_bit = (bit_cnt_q == 3'h0) ? grp[GROUP_BITS-1] : shreg_q[GROUP_BITS-1];

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         bit_cnt_q <= 3'h0;
         shreg_q <= CG_IDLE;
         code_group_out <= CG_IDLE;
      end else if (advance) begin
         if (bit_cnt_q == 3'h0) begin
            shreg_q <= {grp[GROUP_BITS-2:0], 1'b0};
            bit_cnt_q <= GROUP_LAST_BIT;
            code_group_out <= grp;
         end else begin
            shreg_q <= {shreg_q[GROUP_BITS-2:0], 1'b0};
            bit_cnt_q <= bit_cnt_q - 3'h1;
         end
      end
   end

   // scrambler, nrzi and mlt-3 line coding
   logic [LFSR_W-1:0] lfsr_q;
   logic scr_bit, mlt3_up_q;

   assign scr_bit = cur_bit ^ lfsr_q[LFSR_W-1]; // RULE18

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         lfsr_q <= {SEED_FILL, phy_addr_in}; // RULE15
      end else if (advance) begin
         lfsr_q <= {lfsr_q[LFSR_W-2:0], lfsr_q[LFSR_TAP_A] ^ lfsr_q[LFSR_TAP_B]}; // RULE18
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         scr_bit_out <= 1'b0;
         nrzi_out <= 1'b0;
         line_bit_valid_out <= 1'b0;
      end else begin
         line_bit_valid_out <= advance;
         if (advance) begin
            scr_bit_out <= scr_bit;
            nrzi_out <= nrzi_out ^ scr_bit; // RULE16
         end
      end
   end

   // mlt-3 steps through zero, plus, zero, minus on each nrzi transition
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         mlt3_out <= MLT3_ZERO;
         mlt3_up_q <= 1'b1;
      end else if (advance && scr_bit) begin // RULE16 RULE17
         case (mlt3_out)
            MLT3_ZERO: begin
               mlt3_out <= mlt3_up_q ? MLT3_POS : MLT3_NEG;
            end
            MLT3_POS: begin
               mlt3_out <= MLT3_ZERO;
               mlt3_up_q <= 1'b0;
            end
            MLT3_NEG: begin
               mlt3_out <= MLT3_ZERO;
               mlt3_up_q <= 1'b1;
            end
            default: begin
               mlt3_out <= MLT3_ZERO;
            end
         endcase
      end
   end

   // receive code group interpretation
   function automatic logic [4:0] decode_group(input logic [4:0] g);
      logic [4:0] res;
      res = '0;
      for (int i = 0; i < 16; i++) begin
         if (CG_TABLE[i] == g) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction : decode_group

   fetse_rx_state_t rx_st_q, rx_st_d;
   fetse_rx_t rx_d;
   logic last_idle_q;
   logic [4:0] dec;

   assign dec = decode_group(rx_group_in);

   always_comb begin
      rx_st_d = rx_st_q;
      rx_d = rx_nibble_out;
      rx_d.stb = 1'b0;
      rx_d.er = 1'b0;
      if (rx_group_valid_in) begin
         case (rx_st_q)
            RX_IDLE: begin
               if (rx_group_in == CG_SSD_J && last_idle_q) begin
                  rx_d = '{stb: 1'b1, dv: 1'b1, er: 1'b0, crs: 1'b1, data: NIB_PREAMBLE}; // RULE11
                  rx_st_d = RX_GOT_J;
               end else if (rx_group_in == CG_SSD_J || rx_group_in == CG_SSD_K) begin
                  rx_d.er = 1'b1; // RULE11
               end
            end
            RX_GOT_J: begin
               if (rx_group_in == CG_SSD_K) begin
                  rx_d = '{stb: 1'b1, dv: 1'b1, er: 1'b0, crs: 1'b1, data: NIB_PREAMBLE}; // RULE11
                  rx_st_d = RX_DATA;
               end else begin
                  rx_d = '{stb: 1'b1, dv: 1'b0, er: 1'b1, crs: 1'b0, data: NIB_ZERO}; // RULE11
                  rx_st_d = RX_IDLE;
               end
            end
            RX_DATA: begin
               if (dec[4]) begin
                  rx_d.stb = 1'b1;
                  rx_d.data = dec[3:0];
               end else if (rx_group_in == CG_ESD_T) begin
                  rx_st_d = RX_GOT_T;
               end else begin
                  rx_d.stb = 1'b1; // RULE13 RULE14
                  rx_d.er = 1'b1;
               end
            end
            RX_GOT_T: begin
               if (rx_group_in == CG_ESD_R) begin
                  rx_d = '{stb: 1'b0, dv: 1'b0, er: 1'b0, crs: 1'b0, data: NIB_ZERO}; // RULE12
                  rx_st_d = RX_IDLE;
               end else begin
                  rx_d.stb = 1'b1; // RULE12
                  rx_d.er = 1'b1;
                  rx_st_d = RX_DATA;
               end
            end
            default: begin
               rx_d = '0;
               rx_st_d = RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rx_st_q <= RX_IDLE;
         rx_nibble_out <= '0;
         last_idle_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         rx_nibble_out <= rx_d;
         if (rx_group_valid_in) begin
            last_idle_q <= (rx_group_in == CG_IDLE);
         end
      end
   end

endmodule : fetse_symbol_encoder

// ---- fetse_mac_model.sv ----
// behavioural mac driving the mii transmit side of the symbol encoder
`timescale 1ns/100ps
module fetse_mac_model (
   input wire logic tx_clk_in,
   output fetse_pkg::fetse_nib_t nib_out
);
   import fetse_pkg::*;
   initial nib_out = '0;
   // one frame of n nibbles; data lines show the inverse of the last nibble once released
   task automatic send(input int n, input logic [3:0] d [16], input logic [15:0] er);
      for (int i = 0; i < n; i++) begin
         @(posedge tx_clk_in);
         nib_out <= '{en: 1'b1, er: er[i], data: d[i]};
      end
      @(posedge tx_clk_in);
      nib_out <= '{en: 1'b0, er: 1'b0, data: ~d[n-1]};
   endtask : send
endmodule : fetse_mac_model

// ---- fetse_symbol_encoder_checker.sv ----
// port checker of the 100 Mb/s symbol encoder
`timescale 1ns/100ps
module fetse_symbol_encoder_checker #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic tx_clk_in,
   input wire logic mii_txen_in,
   input wire logic mii_txer_in,
   input wire logic [3:0] mii_txd_in,
   input wire logic [fetse_pkg::CTRL2_W-1:0] second_control_register_in,
   input wire logic [4:0] phy_addr_in,
   input wire logic [4:0] rx_group_in,
   input wire logic rx_group_valid_in,
   input wire logic tx_fifo_ready_out,
   input wire logic [4:0] code_group_out,
   input wire logic line_bit_valid_out,
   input wire logic scr_bit_out,
   input wire logic nrzi_out,
   input wire fetse_pkg::fetse_mlt3_t mlt3_out,
   input wire fetse_pkg::fetse_rx_t rx_nibble_out
);
   import fetse_pkg::*;
   logic [4:0] last_grp_q;
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         last_grp_q <= 5'h00;
      end else if (rx_group_valid_in) begin
         last_grp_q <= rx_group_in;
      end
   end
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   nrzi_step_a: assert property (line_bit_valid_out |-> nrzi_out == ($past(nrzi_out) ^ scr_bit_out))
      else $error("nrzi level does not follow scrambled bit");
   mlt3_hold_a: assert property (line_bit_valid_out && !scr_bit_out |-> $stable(mlt3_out))
      else $error("mlt3 level moved on a zero bit");
   mlt3_step_a: assert property (line_bit_valid_out && scr_bit_out |-> !$stable(mlt3_out))
      else $error("mlt3 level held on a one bit");
   mlt3_center_a: assert property (line_bit_valid_out && scr_bit_out && $past(mlt3_out) != MLT3_ZERO
      |-> mlt3_out == MLT3_ZERO)
      else $error("mlt3 skipped the zero level");
   line_quiet_a: assert property (!line_bit_valid_out |-> $stable(nrzi_out) && $stable(scr_bit_out))
      else $error("line changed without a bit strobe");
   rx_invalid_a: assert property (rx_group_valid_in && rx_nibble_out.dv && rx_group_in inside
      {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08} |=> rx_nibble_out.er)
      else $error("invalid group in data not flagged");
   rx_idle_data_a: assert property (rx_group_valid_in && rx_nibble_out.dv && rx_group_in == CG_IDLE
      |=> rx_nibble_out.er)
      else $error("idle group in data not flagged");
   rx_start_a: assert property (rx_group_valid_in && rx_group_in == CG_SSD_J && last_grp_q == CG_IDLE
      && !rx_nibble_out.crs |=> rx_nibble_out.stb && !rx_nibble_out.er
      && rx_nibble_out.data == NIB_PREAMBLE)
      else $error("start group not decoded");
   rx_end_a: assert property (rx_group_valid_in && rx_group_in == CG_ESD_R && last_grp_q == CG_ESD_T
      && rx_nibble_out.crs |=> !rx_nibble_out.crs && !rx_nibble_out.dv)
      else $error("end pair did not drop carrier");
   cover property (code_group_out == CG_TX_ERR);
   cover property (line_bit_valid_out && mlt3_out == MLT3_NEG);
   cover property (rx_group_valid_in && rx_group_in == CG_ESD_R && last_grp_q == CG_ESD_T);
endmodule : fetse_symbol_encoder_checker
bind fetse_symbol_encoder fetse_symbol_encoder_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_checker (
   .clk_in(clk_in), .rstn_in(rstn_in), .tx_clk_in(tx_clk_in), .mii_txen_in(mii_txen_in),
   .mii_txer_in(mii_txer_in), .mii_txd_in(mii_txd_in), .phy_addr_in(phy_addr_in),
   .second_control_register_in(second_control_register_in), .rx_group_in(rx_group_in),
   .rx_group_valid_in(rx_group_valid_in), .tx_fifo_ready_out(tx_fifo_ready_out),
   .code_group_out(code_group_out), .line_bit_valid_out(line_bit_valid_out),
   .scr_bit_out(scr_bit_out), .nrzi_out(nrzi_out), .mlt3_out(mlt3_out),
   .rx_nibble_out(rx_nibble_out)
);

// ---- tb.sv ----
// self-checking bench of the 100 Mb/s symbol encoder
`timescale 1ns/100ps
module tb;
   import fetse_pkg::*;
   logic clk_in, tx_clk_in, rstn_in, rx_vld, rx_vld_q, fifo_rdy, bit_vld, scr_bit, nrzi, b;
   logic [15:0] ctrl2;
   logic [4:0] phy_addr, rx_grp, cg_out, win, ex;
   logic [10:0] scr_q;
   logic [15:0] m;
   logic [31:0] rnd = 32'hD246;
   fetse_nib_t nib;
   fetse_mlt3_t mlt3;
   fetse_rx_t rx_nib;
   logic [4:0] exp_cg [$];
   logic [15:0] exp_rx [$];
   int error_cnt = 0;
   int n_compared = 0;
   int in_frame = 0;
   int bit_n = 0;
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   initial begin
      tx_clk_in = 1'b0;
      #37.3;
      forever #80 tx_clk_in = ~tx_clk_in;
   end
   fetse_mac_model u_mac (.tx_clk_in(tx_clk_in), .nib_out(nib));
   fetse_symbol_encoder u_dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .tx_clk_in(tx_clk_in), .mii_txen_in(nib.en),
      .mii_txer_in(nib.er), .mii_txd_in(nib.data), .second_control_register_in(ctrl2),
      .phy_addr_in(phy_addr), .rx_group_in(rx_grp), .rx_group_valid_in(rx_vld),
      .tx_fifo_ready_out(fifo_rdy), .code_group_out(cg_out), .line_bit_valid_out(bit_vld),
      .scr_bit_out(scr_bit), .nrzi_out(nrzi), .mlt3_out(mlt3), .rx_nibble_out(rx_nib)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // line watcher: descrambles, checks idle bits and frames groups against the notes
   always @(posedge clk_in) begin
      if (!rstn_in) begin
         scr_q = {SEED_FILL, phy_addr};
         win = CG_IDLE;
         in_frame = 0;
      end else if (bit_vld) begin
         b = scr_bit ^ scr_q[LFSR_W-1];
         scr_q = {scr_q[LFSR_W-2:0], scr_q[LFSR_TAP_A] ^ scr_q[LFSR_TAP_B]};
         win = {win[3:0], b};
         n_compared++;
         if (in_frame == 0 && win == CG_SSD_J) begin
            in_frame = 1;
            bit_n = 4;
         end else if (in_frame == 0 && b !== 1'b1 && win[2:0] != 3'h6 && win[3:0] != 4'hC) begin
            error_cnt++;
            $display("MISMATCH idle bit expected 1 seen %b", b);
         end
         if (in_frame != 0) begin
            bit_n++;
            if (bit_n == 5) begin
               bit_n = 0;
               ex = exp_cg.size() > 0 ? exp_cg.pop_front() : CG_IDLE;
               if (win !== ex) begin
                  error_cnt++;
                  $display("MISMATCH code group expected %b seen %b", ex, win);
               end
               if (cg_out !== ex) begin
                  error_cnt++;
                  $display("MISMATCH code group out expected %b seen %b", ex, cg_out);
               end
               if (win == CG_ESD_R) begin
                  in_frame = 0;
               end
            end
         end
      end
   end
   // receive watcher: one decoded result per group, one cycle later
   always @(posedge clk_in) begin
      rx_vld_q <= rx_vld & rstn_in;
      if (rx_vld_q) begin
         m = exp_rx.pop_front();
         n_compared++;
         if ((rx_nib & m[15:8]) !== m[7:0]) begin
            error_cnt++;
            $display("MISMATCH rx nibble expected %h seen %h", m[7:0], rx_nib & m[15:8]);
         end
      end
   end
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   task automatic do_reset(input logic [4:0] addr);
      @(posedge clk_in);
      rstn_in <= 1'b0;
      phy_addr <= addr;
      repeat (4) @(posedge tx_clk_in);
      @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge tx_clk_in);
   endtask : do_reset
   task automatic rx_test();
      logic [4:0] g [24] = '{CG_IDLE, CG_SSD_J, CG_SSD_K, 5'h00, 5'h1D, 5'h00, 5'h08, CG_IDLE,
         CG_ESD_T, CG_ESD_R, CG_SSD_K, CG_IDLE, CG_SSD_J, 5'h09, CG_IDLE, CG_SSD_J, CG_SSD_K,
         CG_ESD_T, 5'h1E, CG_ESD_R, CG_SSD_J, CG_ESD_T, CG_ESD_R, CG_IDLE};
      logic [15:0] e [24] = '{16'hF000, 16'hFFD5, 16'hFFD5, 16'h0, 16'hFFDF, 16'hF0F0,
         16'hF0F0, 16'hF0F0, 16'hF050, 16'hF000, 16'h7020, 16'hF000, 16'hFFD5, 16'h7020,
         16'hF000, 16'hFFD5, 16'hFFD5, 16'hF050, 16'h7070, 16'hF0F0, 16'hF0F0, 16'hF050,
         16'hF000, 16'hF000};
      rnd = lfsr(rnd);
      g[3] = CG_TABLE[rnd[3:0]];
      e[3] = {12'hFFD, rnd[3:0]};
      for (int i = 0; i < 24; i++) begin
         @(posedge clk_in);
         rx_grp <= g[i];
         rx_vld <= 1'b1;
         exp_rx.push_back(e[i]);
      end
      @(posedge clk_in);
      rx_vld <= 1'b0;
      repeat (3) @(posedge clk_in);
      $display("test receive decode done");
   endtask : rx_test
   task automatic tx_frame(input int n, input logic fwd_off);
      logic [3:0] d [16];
      logic [15:0] er;
      int w;
      @(posedge clk_in);
      ctrl2[CTRL2_TXERR_FWD_DIS_BIT] <= fwd_off;
      repeat (4) @(posedge tx_clk_in);
      rnd = lfsr(rnd);
      er = '0;
      if (n > 1) begin
         er[n-2] = rnd[8];
      end
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         d[i] = i < 2 ? NIB_PREAMBLE : rnd[3:0];
         exp_cg.push_back(i == 0 ? CG_SSD_J : i == 1 ? CG_SSD_K :
            er[i] ? CG_TX_ERR : CG_TABLE[d[i]]);
      end
      if (n == 1) begin
         exp_cg.push_back(CG_SSD_K);
      end else if (n % 2 == 1 && !fwd_off) begin
         exp_cg.push_back(CG_TX_ERR);
      end
      exp_cg.push_back(CG_ESD_T);
      exp_cg.push_back(CG_ESD_R);
      u_mac.send(n, d, er);
      n_compared++;
      if (fifo_rdy !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH fifo ready expected 1 seen %b", fifo_rdy);
      end
      w = 0;
      while ((exp_cg.size() > 0 || in_frame != 0) && w < 4000) begin
         @(posedge clk_in);
         w++;
      end
      if (w >= 4000) begin
         error_cnt++;
         $display("MISMATCH frame end expected done seen timeout");
         results();
      end else begin
         $display("test frame of %0d nibbles, forwarding off %0b done", n, fwd_off);
      end
   endtask : tx_frame
   initial begin
      rstn_in = 1'b0;
      ctrl2 = '0;
      phy_addr = 5'h0B;
      rx_grp = CG_IDLE;
      rx_vld = 1'b0;
      do_reset(5'h0B);
      rx_test();
      for (int k = 0; k < 4; k++) begin
         tx_frame(k[0] ? 5 : 6, k[1]);
      end
      do_reset(5'h16);
      tx_frame(7, 1'b0);
      tx_frame(1, 1'b1);
      results();
   end
endmodule : tb
